// file: rtl/oau_pkg.sv
package oau_pkg;

  // ----------------------------------------------------------------
  // Core register file
  // ----------------------------------------------------------------
  localparam int DATA_W = 20;
  localparam int NUM_GP = 12;
  localparam logic [3:0] REG_PC = 4'h0;
  localparam logic [3:0] REG_SP = 4'h1;
  localparam logic [3:0] REG_SR = 4'h2;
  localparam logic [3:0] REG_CG2 = 4'h3;
  localparam logic [3:0] FIRST_GP = 4'h4;

  // ----------------------------------------------------------------
  // Addressing mode codes
  // ----------------------------------------------------------------
  localparam logic [1:0] SRC_REG = 2'h0;
  localparam logic [1:0] SRC_IDX = 2'h1;
  localparam logic [1:0] SRC_IND = 2'h2;
  localparam logic [1:0] SRC_AUTO = 2'h3;
  localparam logic DST_REG = 1'h0;
  localparam logic DST_IDX = 1'h1;
  localparam logic [1:0] EXT_DATA_AL_BW = 2'h1;
  localparam logic [3:0] LOW_64K_NIBBLE = 4'h0;

  // ----------------------------------------------------------------
  // Generated constants and increments
  // ----------------------------------------------------------------
  localparam logic [19:0] CONST_0 = 20'h00000;
  localparam logic [19:0] CONST_1 = 20'h00001;
  localparam logic [19:0] CONST_2 = 20'h00002;
  localparam logic [19:0] CONST_4 = 20'h00004;
  localparam logic [19:0] CONST_8 = 20'h00008;
  localparam logic [19:0] CONST_ALL_ONES = 20'hFFFFF;
  localparam logic [19:0] INC_BYTE = 20'h00001;
  localparam logic [19:0] INC_WORD = 20'h00002;
  localparam logic [19:0] INC_ADDR = 20'h00004;
  localparam logic [2:0] LEN_ONE = 3'h1;

  // ----------------------------------------------------------------
  // Register bus map
  // ----------------------------------------------------------------
  localparam int AXI_ADDR_W = 8;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [1:0] GP_WINDOW_SEL = 2'h1;
  localparam logic CTRL_EN_RST = 1'h1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {W_BYTE, W_WORD, W_ADDR} width_t;

  typedef struct packed {
    logic [1:0] src_mode_field;
    logic [3:0] src_reg;
    logic dst_mode;
    logic [3:0] dst_reg;
    logic byte_word;
    logic long_addr;
    logic ext_present;
    logic [3:0] src_ext;
    logic [3:0] dst_ext;
    logic [15:0] src_word;
    logic [15:0] dst_word;
    logic [19:0] pc;
  } dec_req_t;

  typedef struct packed {
    width_t width;
    logic src_is_mem;
    logic [19:0] src_addr;
    logic [19:0] src_value;
    logic dst_is_mem;
    logic [19:0] dst_addr;
    logic [19:0] dst_value;
    logic [2:0] length;
  } dec_rsp_t;

  typedef struct packed {
    logic [3:0] dst_reg;
    logic [19:0] data;
    width_t width;
    logic sign_extend_op;
  } wb_req_t;

endpackage

// file: rtl/operand_addressing_unit.sv
`timescale 1ns/1ps
module operand_addressing_unit (
  // Clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // Decode request from fetch
  input wire logic req_valid,
  input wire oau_pkg::dec_req_t req,
  output logic req_ready,
  // Decode answer
  output logic rsp_valid,
  output oau_pkg::dec_rsp_t rsp,
  // Result write-back
  input wire logic wb_valid,
  input wire oau_pkg::wb_req_t wb,
  // AXI4-Lite write channels
  input wire logic [oau_pkg::AXI_ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read channels
  input wire logic [oau_pkg::AXI_ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [oau_pkg::NUM_GP-1:0][19:0] gp;
    logic [15:0] sr;
    logic en;
    logic [15:0] dec_cnt;
    logic req_ready;
    logic rsp_valid;
    oau_pkg::dec_rsp_t rsp;
    logic awready;
    logic wready;
    logic aw_held;
    logic w_held;
    logic [oau_pkg::AXI_ADDR_W-1:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } st_t;

  st_t state_r;
  st_t state_nxt;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [19:0] width_mask(logic [19:0] v, oau_pkg::width_t w);
    case (w)
      oau_pkg::W_BYTE: return {12'h000, v[7:0]};
      oau_pkg::W_WORD: return {4'h0, v[15:0]};
      default: return v;
    endcase
  endfunction

  function automatic logic [19:0] inc_of(oau_pkg::width_t w);
    case (w)
      oau_pkg::W_BYTE: return oau_pkg::INC_BYTE;
      oau_pkg::W_WORD: return oau_pkg::INC_WORD;
      default: return oau_pkg::INC_ADDR;
    endcase
  endfunction

  // Stack pointer is not modelled here and reads as zero
  function automatic logic [19:0] reg_read(st_t s, logic [3:0] num, logic [19:0] pc);
    logic [3:0] k;
    k = num - oau_pkg::FIRST_GP;
    case (num)
      oau_pkg::REG_PC: return pc;
      oau_pkg::REG_SR: return {4'h0, s.sr};
      oau_pkg::REG_SP: return oau_pkg::CONST_0;
      oau_pkg::REG_CG2: return oau_pkg::CONST_0;
      default: return s.gp[k];
    endcase
  endfunction

  // Without an extension word the index is a signed word; a base in the
  // lower 64 KB wraps inside it so old 16-bit code keeps working.
  function automatic logic [19:0] index_addr(logic [19:0] base, logic ext,
                                             logic [3:0] hi, logic [15:0] word);
    logic [19:0] sum;
    sum = base + {{4{word[15]}}, word};
    if (ext) begin
      sum = base + {hi, word};
    end else if (base[19:16] == oau_pkg::LOW_64K_NIBBLE) begin
      sum[19:16] = 4'h0;
    end
    return sum;
  endfunction

  function automatic oau_pkg::width_t width_of(oau_pkg::dec_req_t q);
    if (q.ext_present) begin
      if ({q.long_addr, q.byte_word} == oau_pkg::EXT_DATA_AL_BW) begin
        return oau_pkg::W_ADDR;
      end else if (q.byte_word) begin
        return oau_pkg::W_BYTE;
      end else begin
        return oau_pkg::W_WORD;
      end
    end else if (q.byte_word) begin
      return oau_pkg::W_BYTE;
    end else begin
      return oau_pkg::W_WORD;
    end
  endfunction

  // Source and destination are decoded independently
  function automatic oau_pkg::dec_rsp_t decode(st_t s, oau_pkg::dec_req_t q);
    oau_pkg::dec_rsp_t r;
    logic [19:0] sbase;
    logic [19:0] dbase;
    r = '0;
    r.width = width_of(q);
    r.length = oau_pkg::LEN_ONE + {2'h0, q.ext_present};
    sbase = reg_read(s, q.src_reg, q.pc);
    dbase = reg_read(s, q.dst_reg, q.pc);
    case (q.src_mode_field)
      oau_pkg::SRC_REG: begin
        r.src_value = width_mask(sbase, r.width);
      end
      oau_pkg::SRC_IDX: begin
        if (q.src_reg == oau_pkg::REG_CG2) begin
          r.src_value = oau_pkg::CONST_1;
        end else begin
          if (q.src_reg == oau_pkg::REG_SR) begin
            sbase = oau_pkg::CONST_0;
          end
          r.src_is_mem = 1'b1;
          r.src_addr = index_addr(sbase, q.ext_present, q.src_ext, q.src_word);
          r.length = r.length + 3'h1;
        end
      end
      oau_pkg::SRC_IND: begin
        if (q.src_reg == oau_pkg::REG_SR) begin
          r.src_value = oau_pkg::CONST_4;
        end else if (q.src_reg == oau_pkg::REG_CG2) begin
          r.src_value = oau_pkg::CONST_2;
        end else begin
          r.src_is_mem = 1'b1;
          r.src_addr = sbase;
        end
      end
      default: begin
        if (q.src_reg == oau_pkg::REG_SR) begin
          r.src_value = oau_pkg::CONST_8;
        end else if (q.src_reg == oau_pkg::REG_CG2) begin
          r.src_value = width_mask(oau_pkg::CONST_ALL_ONES, r.width);
        end else if (q.src_reg == oau_pkg::REG_PC) begin
          r.src_value = width_mask({q.ext_present ? q.src_ext : 4'h0, q.src_word},
                                   r.width);
          r.length = r.length + 3'h1;
        end else begin
          r.src_is_mem = 1'b1;
          r.src_addr = sbase;
        end
      end
    endcase
    if (q.dst_mode == oau_pkg::DST_IDX) begin
      if (q.dst_reg == oau_pkg::REG_SR) begin
        dbase = oau_pkg::CONST_0;
      end
      r.dst_is_mem = 1'b1;
      r.dst_addr = index_addr(dbase, q.ext_present, q.dst_ext, q.dst_word);
      r.length = r.length + 3'h1;
    end else begin
      r.dst_value = width_mask(dbase, r.width);
    end
    return r;
  endfunction

  function automatic logic [31:0] bus_read(st_t s, logic [oau_pkg::AXI_ADDR_W-1:0] a);
    logic [3:0] k;
    k = a[5:2];
    if (a == oau_pkg::OFF_CTRL) begin
      return {31'h00000000, s.en};
    end else if (a == oau_pkg::OFF_STATUS) begin
      return {14'h0000, s.rsp.width, s.dec_cnt};
    end else begin
      return {12'h000, s.gp[k]};
    end
  endfunction

  function automatic logic bus_hit(logic [oau_pkg::AXI_ADDR_W-1:0] a);
    return (a == oau_pkg::OFF_CTRL) || (a == oau_pkg::OFF_STATUS) ||
           ((a[7:6] == oau_pkg::GP_WINDOW_SEL) && (a[5:2] < 4'(oau_pkg::NUM_GP)) &&
            (a[1:0] == 2'h0));
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    state_nxt.rsp_valid = 1'b0;

    // Bus write: address and data are taken in either order
    if (state_r.bvalid && bready) begin
      state_nxt.bvalid = 1'b0;
    end
    if (awvalid && state_r.awready) begin
      state_nxt.aw_held = 1'b1;
      state_nxt.wr_addr = awaddr;
    end
    if (wvalid && state_r.wready) begin
      state_nxt.w_held = 1'b1;
      state_nxt.wr_data = wdata;
      state_nxt.wr_strb = wstrb;
    end
    if (state_r.aw_held && state_r.w_held && !state_r.bvalid) begin
      state_nxt.aw_held = 1'b0;
      state_nxt.w_held = 1'b0;
      state_nxt.bvalid = 1'b1;
      state_nxt.bresp = bus_hit(state_r.wr_addr) ? oau_pkg::RESP_OKAY : oau_pkg::RESP_SLVERR;
      if (state_r.wr_addr == oau_pkg::OFF_CTRL && state_r.wr_strb[0]) begin
        state_nxt.en = state_r.wr_data[0];
      end
      for (int i = 0; i < oau_pkg::NUM_GP; i++) begin
        if (bus_hit(state_r.wr_addr) && state_r.wr_addr[7:6] == oau_pkg::GP_WINDOW_SEL &&
            state_r.wr_addr[5:2] == 4'(i)) begin
          for (int b = 0; b < 3; b++) begin
            if (state_r.wr_strb[b]) begin
              state_nxt.gp[i][b*8 +: 4] = state_r.wr_data[b*8 +: 4];
              if (b < 2) begin
                state_nxt.gp[i][b*8+4 +: 4] = state_r.wr_data[b*8+4 +: 4];
              end
            end
          end
        end
      end
    end
    state_nxt.awready = !state_nxt.aw_held;
    state_nxt.wready = !state_nxt.w_held;

    // Bus read: one outstanding answer
    if (state_r.rvalid && rready) begin
      state_nxt.rvalid = 1'b0;
    end
    if (arvalid && state_r.arready) begin
      state_nxt.rvalid = 1'b1;
      state_nxt.rdata = bus_hit(araddr) ? bus_read(state_r, araddr) : 32'h00000000;
      state_nxt.rresp = bus_hit(araddr) ? oau_pkg::RESP_OKAY : oau_pkg::RESP_SLVERR;
    end
    state_nxt.arready = !state_nxt.rvalid;

    // Decode; the pointer bump lands on the same edge as the answer
    if (req_valid && state_r.req_ready) begin
      state_nxt.rsp = decode(state_r, req);
      state_nxt.rsp_valid = 1'b1;
      state_nxt.dec_cnt = state_r.dec_cnt + 16'h0001;
      for (int i = 0; i < oau_pkg::NUM_GP; i++) begin
        if (req.src_mode_field == oau_pkg::SRC_AUTO &&
            req.src_reg == 4'(i + 4)) begin
          state_nxt.gp[i] = state_r.gp[i] + inc_of(width_of(req));
        end
      end
    end

    // Write-back of a result wins over a bump of the same register
    // Only the named destination changes, never the source
    if (wb_valid) begin
      for (int i = 0; i < oau_pkg::NUM_GP; i++) begin
        if (wb.dst_reg == 4'(i + 4)) begin
          if (wb.sign_extend_op) begin
            state_nxt.gp[i] = {{12{state_nxt.gp[i][7]}}, state_nxt.gp[i][7:0]};
          end else begin
            state_nxt.gp[i] = width_mask(wb.data, wb.width);
          end
        end
      end
      if (wb.dst_reg == oau_pkg::REG_SR) begin
        state_nxt.sr = wb.data[15:0];
      end
    end

    state_nxt.req_ready = state_nxt.en;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= '0;
      state_r.en <= oau_pkg::CTRL_EN_RST;
      state_r.req_ready <= oau_pkg::CTRL_EN_RST;
      state_r.awready <= 1'b1;
      state_r.wready <= 1'b1;
      state_r.arready <= 1'b1;
    end else if (ce) begin
      state_r <= state_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign req_ready = state_r.req_ready;
  assign rsp_valid = state_r.rsp_valid;
  assign rsp = state_r.rsp;
  assign awready = state_r.awready;
  assign wready = state_r.wready;
  assign bresp = state_r.bresp;
  assign bvalid = state_r.bvalid;
  assign arready = state_r.arready;
  assign rdata = state_r.rdata;
  assign rresp = state_r.rresp;
  assign rvalid = state_r.rvalid;

endmodule

// file: tb/oau_fetch_model.sv
`timescale 1ns/1ps
module oau_fetch_model (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bench side
  input wire logic issue,
  input wire oau_pkg::dec_req_t next_req,
  // Decode port
  input wire logic req_ready,
  output logic req_valid,
  output oau_pkg::dec_req_t req
);
  // -----------------------------------------------------------
  // Request hold
  // -----------------------------------------------------------
  // Payload is inverted once taken so a stale word never looks valid
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      req_valid <= 1'h0;
      req <= '0;
    end else if (req_valid && req_ready) begin
      req_valid <= 1'h0;
      req <= ~req;
    end else if (issue && !req_valid) begin
      req_valid <= 1'h1;
      req <= next_req;
    end
  end
endmodule

// file: tb/operand_addressing_unit_asserts.sv
`timescale 1ns/1ps
module operand_addressing_unit_asserts (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // Decode port
  input wire logic req_valid,
  input wire oau_pkg::dec_req_t req,
  input wire logic req_ready,
  input wire logic rsp_valid,
  input wire oau_pkg::dec_rsp_t rsp
);
  // -----------------------------------------------------------
  // Decode checks
  // -----------------------------------------------------------
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic tk;
  logic gp;
  assign tk = ce && req_valid && req_ready;
  assign gp = req.src_reg >= oau_pkg::FIRST_GP;
  // A frozen clock enable holds the answer, so it is not a second pulse
  property p_answer; tk |=> rsp_valid ##1 (!rsp_valid || $past(tk) || !$past(ce)); endproperty
  a_answer: assert property (p_answer) else $error("answer not a single pulse");
  property p_only; rsp_valid |-> $past(tk) || !$past(ce); endproperty
  a_only: assert property (p_only) else $error("answer without request");
  property p_reg; tk && req.src_mode_field == oau_pkg::SRC_REG && gp |=> !rsp.src_is_mem;
  endproperty
  a_reg: assert property (p_reg) else $error("register mode went to memory");
  property p_ind; tk && req.src_mode_field == oau_pkg::SRC_IND && gp |=> rsp.src_is_mem;
  endproperty
  a_ind: assert property (p_ind) else $error("indirect mode not memory");
  property p_sym;
    tk && req.src_mode_field == oau_pkg::SRC_IDX && req.src_reg == oau_pkg::REG_PC
      && !req.ext_present && req.pc[19:16] == 4'h0
    |=> rsp.src_addr == {4'h0, $past(req.pc[15:0]) + $past(req.src_word)};
  endproperty
  a_sym: assert property (p_sym) else $error("symbolic address wrong");
  property p_abs;
    tk && req.src_mode_field == oau_pkg::SRC_IDX && req.src_reg == oau_pkg::REG_SR
      && !req.ext_present |=> rsp.src_addr == {4'h0, $past(req.src_word)};
  endproperty
  a_abs: assert property (p_abs) else $error("absolute address wrong");
  property p_cg;
    tk && req.src_mode_field == oau_pkg::SRC_IND && req.src_reg == oau_pkg::REG_CG2
    |=> rsp.src_value == oau_pkg::CONST_2;
  endproperty
  a_cg: assert property (p_cg) else $error("constant two wrong");
  property p_len;
    tk && req.src_mode_field == oau_pkg::SRC_REG && req.dst_mode == oau_pkg::DST_REG
    |=> rsp.length == {2'h0, $past(req.ext_present)} + oau_pkg::LEN_ONE;
  endproperty
  a_len: assert property (p_len) else $error("register mode length wrong");
  property p_alen;
    tk && req.ext_present && {req.long_addr, req.byte_word} == oau_pkg::EXT_DATA_AL_BW
    |=> rsp.width == oau_pkg::W_ADDR;
  endproperty
  a_alen: assert property (p_alen) else $error("address-word width missed");
  c_auto: cover property (tk && req.src_mode_field == oau_pkg::SRC_AUTO);
  c_ext: cover property (tk && req.ext_present);
  c_idx: cover property (tk && req.src_mode_field == oau_pkg::SRC_IDX && gp);
endmodule
bind operand_addressing_unit operand_addressing_unit_asserts u_operand_addressing_unit_asserts (
  .aclk(aclk), .aresetn(aresetn), .ce(ce), .req_valid(req_valid), .req(req),
  .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp(rsp));

// file: tb/operand_addressing_unit_tb_top.sv
`timescale 1ns/1ps
module operand_addressing_unit_tb_top;
  // -----------------------------------------------------------
  // Signals and instances
  // -----------------------------------------------------------
  logic aclk = 1'h0;
  logic ce = 1'h1;
  logic [3:0] cr [9] = '{4'h3, 4'h3, 4'h3, 4'h3, 4'h2, 4'h2, 4'h0, 4'h2, 4'h0};
  logic [19:0] cx [9] = '{20'h00000, 20'h00001, 20'h00002, 20'h0FFFF, 20'h00004,
    20'h00008, 20'h00010, 20'h01234, 20'h000EF};
  logic aresetn = 1'h0;
  logic issue = 1'h0;
  logic req_valid, req_ready, rsp_valid;
  oau_pkg::dec_req_t req;
  oau_pkg::dec_req_t nreq = '0;
  oau_pkg::dec_rsp_t rsp;
  logic wb_valid = 1'h0;
  oau_pkg::wb_req_t wb = '0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic [1:0] bresp, rresp;
  int err_total = 0;
  int n_compared = 0;
  operand_addressing_unit u_operand_addressing_unit (.aclk(aclk), .aresetn(aresetn),
    .ce(ce), .req_valid(req_valid), .req(req), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp(rsp), .wb_valid(wb_valid), .wb(wb), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready));
  oau_fetch_model u_oau_fetch_model (.aclk(aclk), .aresetn(aresetn), .issue(issue),
    .next_req(nreq), .req_ready(req_ready), .req_valid(req_valid), .req(req));
  initial begin
    forever #25 aclk = ~aclk;
  end
  // -----------------------------------------------------------
  // Tasks and expectations
  // -----------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
      if (bready && bvalid) begin
        bready <= 1'h0;
        chk(bresp, er);
      end
    end while (awvalid || wvalid || bready);
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'h0;
      if (rready && rvalid) begin
        d = rdata;
        rs = rresp;
        rready <= 1'h0;
      end
    end while (arvalid || rready);
  endtask
  // Waits carry no limit of their own: only the watchdog ends a hang
  task automatic dec(input oau_pkg::dec_req_t r);
    nreq <= r;
    issue <= 1'h1;
    @(posedge aclk);
    issue <= 1'h0;
    do begin
      @(posedge aclk);
      #1;
    end while (rsp_valid !== 1'h1);
    @(posedge aclk);
  endtask
  task automatic wbw(input logic [3:0] rd, input logic [19:0] v, input oau_pkg::width_t w,
      input logic sx);
    wb <= '{dst_reg: rd, data: v, width: w, sign_extend_op: sx};
    wb_valid <= 1'h1;
    @(posedge aclk);
    wb_valid <= 1'h0;
    @(posedge aclk);
  endtask
  function automatic logic [7:0] ra(input int n);
    ra = 8'(8'h40 + 4 * (n - 4));
  endfunction
  function automatic logic [19:0] wm(input oau_pkg::width_t w, input logic [19:0] v);
    wm = w == oau_pkg::W_BYTE ? v & 20'h000FF : w == oau_pkg::W_WORD ? v & 20'h0FFFF : v;
  endfunction
  function automatic logic [19:0] inc(input oau_pkg::width_t w);
    inc = w == oau_pkg::W_BYTE ? 20'h1 : w == oau_pkg::W_WORD ? 20'h2 : 20'h4;
  endfunction
  // Without extension the sum stays in the lower 64 KB when the base does
  function automatic logic [19:0] ea(input logic [19:0] b, input logic [15:0] x,
      input logic e, input logic [3:0] xe);
    ea = e ? b + {xe, x} : {4'h0, 16'(b[15:0] + x)};
  endfunction
  // -----------------------------------------------------------
  // Tests
  // -----------------------------------------------------------
  initial begin
    logic [31:0] d;
    logic [1:0] rs;
    logic [19:0] v, wv, x;
    oau_pkg::dec_req_t r;
    oau_pkg::width_t w;
    int rg, m;
    d = $urandom(32'hAEDC);
    repeat (20) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    axr(ra(4), d, rs);
    chk(d, 32'h0);
    axr(8'hFC, d, rs);
    chk(rs, oau_pkg::RESP_SLVERR);
    axw(8'hFC, 32'h1, oau_pkg::RESP_SLVERR);
    for (rg = 4; rg < 16; rg++) begin
      v = 20'($urandom);
      axw(ra(rg), {12'h0, v}, oau_pkg::RESP_OKAY);
      axr(ra(rg), d, rs);
      chk(d, {12'h0, v});
    end
    for (m = 0; m < 3; m++) begin
      w = oau_pkg::width_t'(m);
      v = 20'($urandom) | 20'h80000;
      wbw(4'h5, v, w, 1'h0);
      axr(ra(5), d, rs);
      chk(d, {12'h0, wm(w, v)});
      v = m[0] ? 20'h12380 : 20'h5A37F;
      axw(ra(6), {12'h0, v}, oau_pkg::RESP_OKAY);
      wbw(4'h6, 20'h0, oau_pkg::W_WORD, 1'h1);
      axr(ra(6), d, rs);
      chk(d, {12'h0, {12{v[7]}}, v[7:0]});
    end
    wv = {4'h0, 16'($urandom)};
    axw(ra(15), {12'h0, wv}, oau_pkg::RESP_OKAY);
    for (int k = 0; k < 24; k++) begin
      m = k % 4;
      w = oau_pkg::width_t'($urandom % 3);
      rg = 4 + $urandom % 11;
      v = {4'h0, 16'($urandom)};
      axw(ra(rg), {12'h0, v}, oau_pkg::RESP_OKAY);
      r = '0;
      r.src_mode_field = 2'(m);
      r.src_reg = 4'(rg);
      r.dst_mode = 1'($urandom);
      r.dst_reg = 4'hF;
      r.byte_word = w != oau_pkg::W_WORD;
      r.long_addr = w != oau_pkg::W_ADDR ? 1'($urandom) : 1'h0;
      r.ext_present = w == oau_pkg::W_ADDR || r.long_addr;
      r.src_ext = 4'($urandom);
      r.dst_ext = 4'($urandom);
      r.src_word = 16'($urandom);
      r.dst_word = 16'($urandom);
      r.pc = {4'h0, 16'($urandom)};
      dec(r);
      chk(rsp.width, w);
      chk(rsp.src_is_mem, m != 0);
      x = m == 1 ? ea(v, r.src_word, r.ext_present, r.src_ext) : v;
      chk(m == 0 ? rsp.src_value : rsp.src_addr, m == 0 ? wm(w, v) : x);
      chk(rsp.length, 1 + r.ext_present + (m == 1) + r.dst_mode);
      chk(rsp.dst_is_mem, r.dst_mode);
      if (r.dst_mode) chk(rsp.dst_addr, ea(wv, r.dst_word, r.ext_present, r.dst_ext));
      else chk(rsp.dst_value, wm(w, wv));
      axr(ra(rg), d, rs);
      x = m == 3 ? v + inc(w) : v;
      chk(d, {12'h0, x});
    end
    for (int k = 0; k < 9; k++) begin
      r = '0;
      r.src_mode_field = k < 4 ? 2'(k) : k == 4 ? 2'h2 : k < 8 && k > 5 ? 2'h1 : 2'h3;
      r.src_reg = cr[k];
      r.byte_word = k == 8;
      r.pc = 20'h0FFF0;
      r.src_word = k == 8 ? 16'hBEEF : k == 7 ? 16'h1234 : 16'h0020;
      dec(r);
      x = k == 6 || k == 7 ? rsp.src_addr : rsp.src_value;
      chk(x, cx[k]);
    end
    // A write-back offered while the clock enable is low must not land
    axw(ra(4), 32'h00000080, oau_pkg::RESP_OKAY);
    ce <= 1'h0;
    wbw(4'h4, 20'h00000, oau_pkg::W_WORD, 1'h1);
    ce <= 1'h1;
    axr(ra(4), d, rs);
    chk(d, 32'h00000080);
    axr(oau_pkg::OFF_STATUS, d, rs);
    chk(d, {14'h0000, 2'(oau_pkg::W_BYTE), 16'h0021});
    axw(oau_pkg::OFF_CTRL, 32'h00000000, oau_pkg::RESP_OKAY);
    chk(req_ready, 1'h0);
    axr(oau_pkg::OFF_CTRL, d, rs);
    chk(d, 32'h00000000);
    axw(oau_pkg::OFF_CTRL, 32'h00000001, oau_pkg::RESP_OKAY);
    chk(req_ready, 1'h1);
    end_sim();
  end
  initial begin
    repeat (20000) @(posedge aclk);
    err_total++;
    end_sim();
  end
endmodule
